// ===== core/dpc_cfg_if.sv
// Configuration fields passed from the register bank to the pin logic.
// Assumes both ends run on one clock.
`timescale 1ns/10ps
`default_nettype none
interface dpc_cfg_if;
  logic [7:0] sync_ovr;
  logic [7:0] gpin_dir;
  logic [3:0] gpin_out;
  logic [3:0] gpin_in;
  logic low_power;
  logic pseq_clk;
  logic hsync_in;
  logic vsync_in;

  modport bank (
    output sync_ovr,
    output gpin_dir,
    output gpin_out,
    output low_power,
    output pseq_clk,
    output hsync_in,
    output vsync_in,
    input gpin_in
  );
  modport pins (
    input sync_ovr,
    input gpin_dir,
    input gpin_out,
    input low_power,
    input pseq_clk,
    input hsync_in,
    input vsync_in,
    output gpin_in
  );
endinterface : dpc_cfg_if
`default_nettype wire

// ===== core/dpc_pins.sv
// Sync override and general pin logic.
// Assumes pin inputs arrive asynchronously and are synchronised here.
`timescale 1ns/10ps
`default_nettype none
module dpc_pins (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration
  dpc_cfg_if.pins cfg,
  // Sync pins
  output logic hsync_o,
  output logic hsync_oe,
  output logic vsync_o,
  output logic vsync_oe,
  // General pins 3 and 2
  input wire logic [3:2] gpin_i,
  output logic [3:2] gpin_o,
  output logic [3:2] gpin_oe
);

  logic [3:2] gpin_meta_q;
  logic [3:2] gpin_sync_q;
  logic [7:0] s;

  assign s = cfg.sync_ovr;

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      gpin_meta_q <= 2'h0;
      gpin_sync_q <= 2'h0;
    end else begin
      gpin_meta_q <= gpin_i;
      gpin_sync_q <= gpin_meta_q;
    end
  end

  // Pins 1 and 0 have their direction elsewhere; they read their own data
  assign cfg.gpin_in = {gpin_sync_q, cfg.gpin_out[1:0]}; // [R14]

  genvar g;
  generate
    for (g = 2; g <= 3; g++) begin : g_gpin
      assign gpin_oe[g] = cfg.gpin_dir[g]; // [R13]
      assign gpin_o[g] = cfg.gpin_out[g]; // [R14]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    if (!s[dpc_pkg::SYNC_V_OVR]) begin
      vsync_o = cfg.vsync_in;
    end else if (s[dpc_pkg::SYNC_V_CLK]) begin
      vsync_o = cfg.pseq_clk; // [R10]
    end else begin
      vsync_o = s[dpc_pkg::SYNC_V_DATA]; // [R10]
    end
    if (!s[dpc_pkg::SYNC_H_OVR]) begin
      hsync_o = cfg.hsync_in;
    end else if (s[dpc_pkg::SYNC_H_CLK]) begin
      hsync_o = cfg.pseq_clk; // [R11]
    end else begin
      hsync_o = s[dpc_pkg::SYNC_H_DATA]; // [R11]
    end
  end

  // Released in low-power modes unless software asks to keep driving
  assign hsync_oe = !cfg.low_power || s[dpc_pkg::SYNC_DRIVE_LOW_PWR]; // [R12]
  assign vsync_oe = hsync_oe; // [R12]

endmodule : dpc_pins
`default_nettype wire

// ===== core/dpc_pkg.sv
// Constants for the DRAM and pin control register bank.
// Assumes an 8-bit indexed I/O port pair on the host bus clock.
package dpc_pkg;

  localparam logic [15:0] IO_INDEX_ADDR = 16'h03d6;
  localparam logic [15:0] IO_DATA_ADDR = 16'h03d7;

  localparam logic [7:0] IDX_MEM_TYPE = 8'h41;
  localparam logic [7:0] IDX_MEM_GEOM = 8'h42;
  localparam logic [7:0] IDX_MEM_IFACE = 8'h43;
  localparam logic [7:0] IDX_MEM_TIMING = 8'h44;
  localparam logic [7:0] IDX_VPORT_CTRL = 8'h60;
  localparam logic [7:0] IDX_SYNC_OVR = 8'h61;
  localparam logic [7:0] IDX_GPIN_DIR = 8'h62;
  localparam logic [7:0] IDX_GPIN_DATA = 8'h63;
  localparam logic [7:0] IDX_PIN_HIZ = 8'h67;

  // Writable masks: bits outside read back as zero
  localparam logic [7:0] MASK_MEM_TYPE = 8'hff;
  localparam logic [7:0] MASK_MEM_GEOM = 8'hff;
  localparam logic [7:0] MASK_MEM_IFACE = 8'hff;
  localparam logic [7:0] MASK_MEM_TIMING = 8'hff;
  localparam logic [7:0] MASK_VPORT_CTRL = 8'h43;
  localparam logic [7:0] MASK_SYNC_OVR = 8'h7f;
  localparam logic [7:0] MASK_GPIN_DIR = 8'h0c;
  localparam logic [7:0] MASK_GPIN_DATA = 8'h0f;
  localparam logic [7:0] MASK_PIN_HIZ = 8'h03;

  // Reset values; interface width field left at 00 (undefined default)
  localparam logic [7:0] RST_MEM_TYPE = 8'h00;
  localparam logic [7:0] RST_MEM_GEOM = 8'h01;
  localparam logic [7:0] RST_MEM_IFACE = 8'h00;
  localparam logic [7:0] RST_MEM_TIMING = 8'h00;
  localparam logic [7:0] RST_VPORT_CTRL = 8'h00;
  localparam logic [7:0] RST_SYNC_OVR = 8'h00;
  localparam logic [7:0] RST_GPIN_DIR = 8'h00;
  localparam logic [7:0] RST_PIN_HIZ = 8'h00;

  // Field positions
  localparam int GEOM_BANK_B_FIXED = 2;
  localparam int IFACE_SPLIT_ROW = 3;
  localparam int TIMING_SHORT = 7;
  localparam int VPORT_CLK_DIV = 6;
  localparam int SYNC_V_CLK = 6;
  localparam int SYNC_H_CLK = 5;
  localparam int SYNC_DRIVE_LOW_PWR = 4;
  localparam int SYNC_V_OVR = 3;
  localparam int SYNC_V_DATA = 2;
  localparam int SYNC_H_OVR = 1;
  localparam int SYNC_H_DATA = 0;
  localparam int HIZ_VPORT = 1;
  localparam int HIZ_MEM = 0;

  localparam logic [1:0] MEM_TYPE_EDO = 2'h1;
  localparam logic [1:0] COL_WIDTH_8 = 2'h0;
  localparam logic [1:0] COL_WIDTH_9 = 2'h1;
  localparam logic [1:0] IFACE_WIDTH_64 = 2'h1;
  localparam logic [1:0] VPORT_OFF = 2'h0;
  localparam logic [1:0] VPORT_FEATURE = 2'h1;
  localparam logic [1:0] VPORT_ZOOMED = 2'h3;

  // Row-to-column delay in half memory clocks
  localparam logic [2:0] RCD_LONG_HALF = 3'h5;
  localparam logic [2:0] RCD_SHORT_HALF = 3'h3;

  localparam logic [3:0] COL_BITS_8 = 4'h8;
  localparam logic [3:0] COL_BITS_9 = 4'h9;

  localparam int FB_BANK_BIT_32 = 18;
  localparam int FB_BANK_BIT_64 = 19;

  typedef enum logic [2:0] {
    VP_OFF = 3'h1,
    VP_FEATURE = 3'h2,
    VP_ZOOMED = 3'h4
  } dpc_vport_e;

endpackage : dpc_pkg

// ===== core/dpc_top.sv
// Register bank for DRAM setup and pin control, behind an indexed I/O port pair.
// Assumes a one-cycle I/O strobe from the host bus decoder on CORE_CLK.
//
// Operation
// [R01] Memory type code 01 means EDO DRAM
// [R02] Column width code 00 eight, 01 nine bits
// [R03] Second bank fixed to eight columns when set
// [R04] Software sets 64-bit width, split strobe first
// [R05] Software writes interface width code 01 only
// [R06] Split strobe picks bank by address bit
// [R07] Row-to-column delay 2.5 or 1.5 clocks
// [R08] Video port clock is dot clock or half
// [R09] Video port mode: off, feature, zoomed input
// [R10] Vertical sync override: data or sequencing clock
// [R11] Horizontal sync override: data or sequencing clock
// [R12] Sync pins released in low power unless kept
// [R13] General pins 3,2 direction bits
// [R14] General data reads pins, writes outputs
// [R15] Video port pins released when bit set
// [R16] Memory pins released when bit set
// [R17] Software writes zero to writable reserved bits
// [R18] Reserved read-only bits read zero
// [R19] Index port 3D6h, data port 3D7h
// [R20] Reset restores documented defaults
`timescale 1ns/10ps
`default_nettype none
module dpc_top (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,

  // Host I/O port
  input wire logic [15:0] IO_ADDR,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic [7:0] IO_WDATA,
  output logic [7:0] IO_RDATA,
  output logic IO_HIT,

  // Memory controller view
  input wire logic [21:0] FB_ADDR,
  output logic [1:0] MEM_TYPE,
  output logic MEM_TYPE_VALID,
  output logic [3:0] COL_BITS_BANK_A,
  output logic [3:0] COL_BITS_BANK_B,
  output logic [2:0] RCD_HALF_CLKS,
  output logic IFACE_IS_64,
  input wire logic ROW_STROBE_N,
  output logic ROW_STROBE_BANK_A_N,
  output logic ROW_STROBE_BANK_B_N,
  output logic MEM_PINS_OE,

  // Video port
  input wire logic DOT_CLOCK,
  output logic VPORT_CLK,
  output logic [2:0] VPORT_MODE,
  output logic VPORT_PINS_OE,

  // Sync and power sequencing
  input wire logic HSYNC_IN,
  input wire logic VSYNC_IN,
  input wire logic LOW_POWER,
  input wire logic PSEQ_CLK,
  output logic HSYNC_O,
  output logic HSYNC_OE,
  output logic VSYNC_O,
  output logic VSYNC_OE,

  // General pins
  input wire logic [3:2] GENERAL_PIN_I,
  output logic [3:2] GENERAL_PIN_O,
  output logic [3:2] GENERAL_PIN_OE,
  output logic [1:0] GENERAL_PIN_LOW_DATA
);

  // Host port
  logic [7:0] index_q;
  logic sel_index;
  logic sel_data;

  // Register contents
  logic [7:0] mem_type_q;
  logic [7:0] mem_geom_q;
  logic [7:0] mem_iface_q;
  logic [7:0] mem_timing_q;
  logic [7:0] vport_ctrl_q;
  logic [7:0] sync_ovr_q;
  logic [7:0] gpin_dir_q;
  logic [3:0] gpin_data_q;
  logic [7:0] hiz_q;

  // Read path
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic [3:0] gpin_rd;

  // Dot clock divider
  logic dot_clock_meta_q;
  logic dot_clock_sync_q;
  logic dot_clock_prev_q;
  logic vclk_div_q;

  // Low-power synchroniser
  logic lp_meta_q;
  logic lp_sync_q;

  // Decoded video port mode
  dpc_pkg::dpc_vport_e vport_mode;

  dpc_cfg_if cfg ();

  // Data port hit for one register index
  function automatic logic hit(input logic [7:0] idx, input logic [7:0] want);
    hit = (idx == want);
  endfunction : hit

  ////////////////////////////////////////////////////////////////////////////
  assign sel_index = (IO_ADDR == dpc_pkg::IO_INDEX_ADDR); // [R19]
  assign sel_data = (IO_ADDR == dpc_pkg::IO_DATA_ADDR); // [R19]
  // Hint for the host bus decoder only
  assign IO_HIT = (IO_WR || IO_RD) && (sel_index || sel_data);

  // Index persists across data accesses
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      index_q <= 8'h00;
    end else if (IO_WR && sel_index) begin
      index_q <= IO_WDATA; // [R19]
    end
  end

  // Each register loads through its writable mask so unused bits stay zero
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      mem_type_q <= dpc_pkg::RST_MEM_TYPE; // [R20]
      mem_geom_q <= dpc_pkg::RST_MEM_GEOM; // [R20]
      mem_iface_q <= dpc_pkg::RST_MEM_IFACE; // [R20]
      mem_timing_q <= dpc_pkg::RST_MEM_TIMING; // [R20]
    end else if (IO_WR && sel_data) begin
      if (hit(index_q, dpc_pkg::IDX_MEM_TYPE)) begin
        mem_type_q <= IO_WDATA & dpc_pkg::MASK_MEM_TYPE;
      end

      if (hit(index_q, dpc_pkg::IDX_MEM_GEOM)) begin
        mem_geom_q <= IO_WDATA & dpc_pkg::MASK_MEM_GEOM;
      end

      if (hit(index_q, dpc_pkg::IDX_MEM_IFACE)) begin
        mem_iface_q <= IO_WDATA & dpc_pkg::MASK_MEM_IFACE;
      end

      if (hit(index_q, dpc_pkg::IDX_MEM_TIMING)) begin
        mem_timing_q <= IO_WDATA & dpc_pkg::MASK_MEM_TIMING;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      vport_ctrl_q <= dpc_pkg::RST_VPORT_CTRL; // [R20]
      sync_ovr_q <= dpc_pkg::RST_SYNC_OVR; // [R20]
      gpin_dir_q <= dpc_pkg::RST_GPIN_DIR; // [R20]
      hiz_q <= dpc_pkg::RST_PIN_HIZ; // [R20]
    end else if (IO_WR && sel_data) begin
      if (hit(index_q, dpc_pkg::IDX_VPORT_CTRL)) begin
        vport_ctrl_q <= IO_WDATA & dpc_pkg::MASK_VPORT_CTRL; // [R18]
      end

      if (hit(index_q, dpc_pkg::IDX_SYNC_OVR)) begin
        sync_ovr_q <= IO_WDATA & dpc_pkg::MASK_SYNC_OVR; // [R18]
      end

      if (hit(index_q, dpc_pkg::IDX_GPIN_DIR)) begin
        gpin_dir_q <= IO_WDATA & dpc_pkg::MASK_GPIN_DIR; // [R18]
      end

      if (hit(index_q, dpc_pkg::IDX_PIN_HIZ)) begin
        hiz_q <= IO_WDATA & dpc_pkg::MASK_PIN_HIZ; // [R18]
      end
    end
  end

  // No documented default: the output latch starts at zero, reads of pins 3 and 2 follow pins, pins 1 and 0 read the latch
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      gpin_data_q <= 4'h0; // [R20]
    end else if (IO_WR && sel_data && hit(index_q, dpc_pkg::IDX_GPIN_DATA)) begin
      gpin_data_q <= IO_WDATA[3:0]; // [R14]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reads of pins 3 and 2 show the synchronised pad level, two cycles late
  assign gpin_rd = cfg.gpin_in; // [R14]

  always_comb begin
    rdata_d = 8'h00;
    if (sel_index) begin
      rdata_d = index_q;
    end else if (sel_data) begin
      // Unknown indexes read as zero
      case (index_q)
        dpc_pkg::IDX_MEM_TYPE: rdata_d = mem_type_q;
        dpc_pkg::IDX_MEM_GEOM: rdata_d = mem_geom_q;
        dpc_pkg::IDX_MEM_IFACE: rdata_d = mem_iface_q;
        dpc_pkg::IDX_MEM_TIMING: rdata_d = mem_timing_q;
        dpc_pkg::IDX_VPORT_CTRL: rdata_d = vport_ctrl_q;
        dpc_pkg::IDX_SYNC_OVR: rdata_d = sync_ovr_q;
        dpc_pkg::IDX_GPIN_DIR: rdata_d = gpin_dir_q;
        dpc_pkg::IDX_GPIN_DATA: rdata_d = {4'h0, gpin_rd}; // [R14] [R18]
        dpc_pkg::IDX_PIN_HIZ: rdata_d = hiz_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      rdata_q <= 8'h00;
    end else if (IO_RD) begin
      rdata_q <= rdata_d;
    end
  end

  // Stands until the next read strobe
  assign IO_RDATA = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Memory controller configuration
  assign MEM_TYPE = mem_type_q[1:0];
  // Reserved type codes are flagged so the controller can stay idle
  assign MEM_TYPE_VALID = (mem_type_q[1:0] == dpc_pkg::MEM_TYPE_EDO); // [R01]

  assign IFACE_IS_64 = (mem_iface_q[5:4] == dpc_pkg::IFACE_WIDTH_64); // [R05]

  always_comb begin
    case (mem_geom_q[1:0])
      dpc_pkg::COL_WIDTH_8: COL_BITS_BANK_A = dpc_pkg::COL_BITS_8; // [R02]
      dpc_pkg::COL_WIDTH_9: COL_BITS_BANK_A = dpc_pkg::COL_BITS_9; // [R02]
      default: COL_BITS_BANK_A = dpc_pkg::COL_BITS_9;
    endcase
  end

  // Fixed width is only meaningful with 64-bit split strobes, set beforehand
  assign COL_BITS_BANK_B = mem_geom_q[dpc_pkg::GEOM_BANK_B_FIXED] ?
                           dpc_pkg::COL_BITS_8 : COL_BITS_BANK_A; // [R03] [R04]

  assign RCD_HALF_CLKS = mem_timing_q[dpc_pkg::TIMING_SHORT] ?
                         dpc_pkg::RCD_SHORT_HALF : dpc_pkg::RCD_LONG_HALF; // [R07]

  // Bank select bit depends on data width; reserved codes treated as 32-bit
  always_comb begin
    ROW_STROBE_BANK_A_N = ROW_STROBE_N;
    ROW_STROBE_BANK_B_N = ROW_STROBE_N;
    if (mem_iface_q[dpc_pkg::IFACE_SPLIT_ROW]) begin
      if (IFACE_IS_64 ? FB_ADDR[dpc_pkg::FB_BANK_BIT_64] :
          FB_ADDR[dpc_pkg::FB_BANK_BIT_32]) begin
        ROW_STROBE_BANK_A_N = 1'b1; // [R06]
      end else begin
        ROW_STROBE_BANK_B_N = 1'b1; // [R06]
      end
    end
  end

  // A set bit floats the pin group
  assign MEM_PINS_OE = !hiz_q[dpc_pkg::HIZ_MEM]; // [R16]
  assign VPORT_PINS_OE = !hiz_q[dpc_pkg::HIZ_VPORT]; // [R15]

  ////////////////////////////////////////////////////////////////////////////
  // Video port clock; dot clock is sampled, so divide is done on its edges
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      dot_clock_meta_q <= 1'b0;
      dot_clock_sync_q <= 1'b0;
      dot_clock_prev_q <= 1'b0;
      vclk_div_q <= 1'b0;
    end else begin
      dot_clock_meta_q <= DOT_CLOCK;
      dot_clock_sync_q <= dot_clock_meta_q;
      dot_clock_prev_q <= dot_clock_sync_q;
      if (dot_clock_sync_q && !dot_clock_prev_q) begin
        vclk_div_q <= !vclk_div_q; // [R08]
      end
    end
  end

  // Undivided path passes the dot clock straight through to avoid skew
  assign VPORT_CLK = vport_ctrl_q[dpc_pkg::VPORT_CLK_DIV] ? vclk_div_q : DOT_CLOCK; // [R08]

  always_comb begin
    case (vport_ctrl_q[1:0])
      dpc_pkg::VPORT_FEATURE: vport_mode = dpc_pkg::VP_FEATURE; // [R09]
      dpc_pkg::VPORT_ZOOMED: vport_mode = dpc_pkg::VP_ZOOMED; // [R09]
      dpc_pkg::VPORT_OFF: vport_mode = dpc_pkg::VP_OFF; // [R09]
      default: vport_mode = dpc_pkg::VP_OFF;
    endcase
  end

  assign VPORT_MODE = vport_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Pin-side logic
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      lp_meta_q <= 1'b0;
      lp_sync_q <= 1'b0;
    end else begin
      lp_meta_q <= LOW_POWER;
      lp_sync_q <= lp_meta_q;
    end
  end

  // Configuration for the pin logic
  assign cfg.sync_ovr = sync_ovr_q;
  assign cfg.gpin_dir = gpin_dir_q;
  assign cfg.gpin_out = gpin_data_q;
  assign cfg.low_power = lp_sync_q;

  assign cfg.pseq_clk = PSEQ_CLK;
  assign cfg.hsync_in = HSYNC_IN;
  assign cfg.vsync_in = VSYNC_IN;

  // Direction of pins 1 and 0 lives elsewhere
  assign GENERAL_PIN_LOW_DATA = gpin_data_q[1:0];

  dpc_pins u_pins (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .cfg(cfg),
    .hsync_o(HSYNC_O),
    .hsync_oe(HSYNC_OE),
    .vsync_o(VSYNC_O),
    .vsync_oe(VSYNC_OE),
    .gpin_i(GENERAL_PIN_I),
    .gpin_o(GENERAL_PIN_O),
    .gpin_oe(GENERAL_PIN_OE)
  );

endmodule : dpc_top
`default_nettype wire

// ===== tb/dpc_asserts.sv
// Port-level checks of the DRAM and pin control register bank.
// Assumes it is bound into dpc_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module dpc_asserts (
  // Clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Host port
  input wire logic [15:0] IO_ADDR,
  input wire logic IO_WR,
  input wire logic IO_RD,
  input wire logic IO_HIT,
  input wire logic [7:0] IO_RDATA,
  // Memory controller view
  input wire logic [21:0] FB_ADDR,
  input wire logic [1:0] MEM_TYPE,
  input wire logic MEM_TYPE_VALID,
  input wire logic [3:0] COL_BITS_BANK_A,
  input wire logic [3:0] COL_BITS_BANK_B,
  input wire logic [2:0] RCD_HALF_CLKS,
  input wire logic IFACE_IS_64,
  input wire logic ROW_STROBE_N,
  input wire logic ROW_STROBE_BANK_A_N,
  input wire logic ROW_STROBE_BANK_B_N,
  input wire logic MEM_PINS_OE,
  // Video, sync and general pins
  input wire logic VPORT_PINS_OE,
  input wire logic [2:0] VPORT_MODE,
  input wire logic LOW_POWER,
  input wire logic HSYNC_OE,
  input wire logic VSYNC_OE,
  input wire logic [3:2] GENERAL_PIN_OE,
  input wire logic [1:0] GENERAL_PIN_LOW_DATA
);
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  logic bank_bit;
  assign bank_bit = IFACE_IS_64 ? FB_ADDR[19] : FB_ADDR[18];
  //////////////////////////////////////////////////////////////////////////////
  AST_MEM_TYPE: assert property (MEM_TYPE_VALID == (MEM_TYPE == 2'h1))
    else $error("memory type valid flag wrong");
  AST_COL_A: assert property (COL_BITS_BANK_A inside {4'h8, 4'h9})
    else $error("bank A column width out of range");
  AST_COL_B: assert property (COL_BITS_BANK_B == COL_BITS_BANK_A
    || COL_BITS_BANK_B == 4'h8)
    else $error("bank B column width wrong");
  AST_RCD: assert property (RCD_HALF_CLKS inside {3'h5, 3'h3})
    else $error("row to column delay wrong");
  AST_ROW_FOLLOW: assert property (
    (ROW_STROBE_BANK_A_N == ROW_STROBE_N || ROW_STROBE_BANK_A_N)
    && (ROW_STROBE_BANK_B_N == ROW_STROBE_N || ROW_STROBE_BANK_B_N)
    && (ROW_STROBE_BANK_A_N == ROW_STROBE_N || ROW_STROBE_BANK_B_N == ROW_STROBE_N))
    else $error("row strobes do not follow the source");
  AST_ROW_SPLIT: assert property ((ROW_STROBE_BANK_A_N != ROW_STROBE_BANK_B_N)
    |-> ((ROW_STROBE_BANK_B_N == ROW_STROBE_N) == bank_bit))
    else $error("split strobe picked the wrong bank");
  AST_VPORT_MODE: assert property (VPORT_MODE inside {3'h1, 3'h2, 3'h4})
    else $error("video port mode not one-hot");
  AST_RESET_DEF: assert property ($rose(RST_N) |-> COL_BITS_BANK_A == 4'h9
    && COL_BITS_BANK_B == 4'h9 && RCD_HALF_CLKS == 3'h5 && MEM_PINS_OE && VPORT_PINS_OE
    && VPORT_MODE == 3'h1 && GENERAL_PIN_OE == 2'h0)
    else $error("outputs not at defaults after reset");
  AST_RD_HOLD: assert property (($past(RST_N) && !$past(IO_RD)) |-> $stable(IO_RDATA))
    else $error("read data moved without a read");
  AST_RD_MISS: assert property ((IO_RD && IO_ADDR != 16'h03d6 && IO_ADDR != 16'h03d7)
    |=> IO_RDATA == 8'h00)
    else $error("foreign address read returned data");
  AST_HIT: assert property (IO_HIT == ((IO_WR || IO_RD) && IO_ADDR[15:1] == 15'h01eb))
    else $error("port hit flag wrong");
  AST_SYNC_OE: assert property ((!LOW_POWER) [*3] |-> HSYNC_OE && VSYNC_OE)
    else $error("sync pins released outside low power");
  AST_LOW_DATA: assert property (($past(RST_N) && !$past(IO_WR))
    |-> $stable(GENERAL_PIN_LOW_DATA))
    else $error("pin data latch moved without a write");
  COV_SPLIT: cover property (ROW_STROBE_BANK_A_N != ROW_STROBE_BANK_B_N);
  COV_LOW_PWR: cover property (!HSYNC_OE && !VSYNC_OE);
  COV_MISS_RD: cover property (IO_RD && IO_ADDR == 16'h03d5);
endmodule : dpc_asserts
`default_nettype wire

// ===== tb/dpc_host.sv
// Host software model: indexed register access over the I/O port pair.
// Assumes one-cycle strobes taken at the next rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module dpc_host (
  // Clock
  input wire logic clk,
  // I/O port toward the device
  output logic [15:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata
);
  initial begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  task acc(input logic [15:0] a, input logic w, input logic r, input logic [7:0] d);
    @(posedge clk);
    #1;
    io_addr = a;
    io_wr = w;
    io_rd = r;
    io_wdata = d;
  endtask : acc
  // Strobes drop; address and data lines show the inverse, so a stale value never matches by luck
  task rel();
    @(posedge clk);
    #1;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_addr = ~io_addr;
    io_wdata = ~io_wdata;
  endtask : rel
  task wr_reg(input logic [7:0] idx, input logic [7:0] val);
    acc(dpc_pkg::IO_INDEX_ADDR, 1'b1, 1'b0, idx);
    acc(dpc_pkg::IO_DATA_ADDR, 1'b1, 1'b0, val);
    rel();
  endtask : wr_reg
  task rd_reg(input logic [7:0] idx, output logic [7:0] val);
    acc(dpc_pkg::IO_INDEX_ADDR, 1'b1, 1'b0, idx);
    acc(dpc_pkg::IO_DATA_ADDR, 1'b0, 1'b1, ~idx);
    rel();
    val = io_rdata;
  endtask : rd_reg
  // Width and split strobe go in before the second-bank bit; reserved bits stay zero
  task setup(input logic [1:0] col, input logic fixed, input logic short_rcd);
    wr_reg(dpc_pkg::IDX_MEM_IFACE, 8'h18);
    wr_reg(dpc_pkg::IDX_MEM_GEOM, {5'h00, fixed, col});
    wr_reg(dpc_pkg::IDX_MEM_TYPE, 8'h01);
    wr_reg(dpc_pkg::IDX_MEM_TIMING, {short_rcd, 7'h00});
  endtask : setup
endmodule : dpc_host
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the DRAM and pin control register bank.
// Assumes dpc_host drives the port; sync, clock and row strobe inputs toggle from a cycle count.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic clk = 1'b0, rst_n = 1'b0, lp = 1'b0;
  logic row_n = 1'b1, dot = 1'b0, pseq = 1'b0, hs = 1'b0, vs = 1'b0;
  logic [21:0] fb = 22'h0;
  logic [1:0] gpi = 2'h0;
  logic [15:0] io_addr;
  logic io_wr, io_rd, mtv, i64, ra, rb, moe, vclk, voe, hso, hsoe, vso, vsoe;
  logic [7:0] io_wdata, io_rdata, rv;
  logic [1:0] mt, gpo, gpoe, gpl;
  logic [3:0] cola, colb;
  logic [2:0] rcd, vmode;
  int cyc = 0, fails = 0, checks_done = 0, n;
  logic [7:0] idx_t [10] = '{8'h41, 8'h42, 8'h43, 8'h44, 8'h60, 8'h61, 8'h62, 8'h63, 8'h67, 8'h50};
  logic [7:0] msk_t [10] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h43, 8'h7f, 8'h0c, 8'h0f, 8'h03, 8'h00};
  logic [7:0] sv_t [6] = '{8'h00, 8'h0a, 8'h0f, 8'h6a, 8'h25, 8'h4b};
  logic [2:0] vm_t [4] = '{3'h1, 3'h2, 3'h1, 3'h4};
  always #25 clk = ~clk;
  dpc_host i_host (.clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata));
  dpc_top i_dut (.CORE_CLK(clk), .RST_N(rst_n), .IO_ADDR(io_addr), .IO_WR(io_wr),
    .IO_RD(io_rd), .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .IO_HIT(), .FB_ADDR(fb),
    .MEM_TYPE(mt), .MEM_TYPE_VALID(mtv), .COL_BITS_BANK_A(cola), .COL_BITS_BANK_B(colb),
    .RCD_HALF_CLKS(rcd), .IFACE_IS_64(i64), .ROW_STROBE_N(row_n), .ROW_STROBE_BANK_A_N(ra),
    .ROW_STROBE_BANK_B_N(rb), .MEM_PINS_OE(moe), .DOT_CLOCK(dot), .VPORT_CLK(vclk),
    .VPORT_MODE(vmode), .VPORT_PINS_OE(voe), .HSYNC_IN(hs), .VSYNC_IN(vs), .LOW_POWER(lp),
    .PSEQ_CLK(pseq), .HSYNC_O(hso), .HSYNC_OE(hsoe), .VSYNC_O(vso), .VSYNC_OE(vsoe),
    .GENERAL_PIN_I(gpi), .GENERAL_PIN_O(gpo), .GENERAL_PIN_OE(gpoe),
    .GENERAL_PIN_LOW_DATA(gpl));
  //////////////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task done(input string s);
    $display("test %s done", s);
  endtask : done
  task conclude();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : conclude
  // Free-running pin stimulus; dot clock is slow enough for an exact half
  always @(posedge clk) begin
    #1;
    cyc++;
    {vs, pseq, dot, hs, row_n} = 5'(cyc);
    if (cyc == 20000) begin
      fails++;
      conclude();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    for (int i = 0; i < 10; i++) begin
      i_host.rd_reg(idx_t[i], rv);
      chk(rv, 8'(i == 1));
    end
    chk(8'(mtv), 8'h00);
    done("reset");
    gpi = 2'h3;
    for (int i = 4; i < 10; i++) begin
      i_host.wr_reg(idx_t[i], 8'hff);
      i_host.rd_reg(idx_t[i], rv);
      chk(rv, msk_t[i]);
    end
    chk(8'({vmode, voe, moe}), 8'h10);
    chk(8'({gpoe, gpo, gpl}), 8'h3f);
    i_host.wr_reg(8'h67, 8'h00);
    chk(8'({voe, moe}), 8'h03);
    done("masks");
    for (int i = 0; i < 6; i++) begin
      i_host.wr_reg(8'h61, sv_t[i]);
      repeat (4) begin
        @(negedge clk);
        chk(8'({hso, vso}), 8'({sv_t[i][1] ? (sv_t[i][5] ? pseq : sv_t[i][0]) : hs,
          sv_t[i][3] ? (sv_t[i][6] ? pseq : sv_t[i][2]) : vs}));
      end
    end
    @(posedge clk) #1 lp = 1'b1;
    i_host.wr_reg(8'h61, 8'h00);
    repeat (3) @(negedge clk);
    chk(8'({hsoe, vsoe}), 8'h00);
    i_host.wr_reg(8'h61, 8'h10);
    chk(8'({hsoe, vsoe}), 8'h03);
    lp = 1'b0;
    done("sync");
    i_host.setup(2'h1, 1'b1, 1'b1);
    chk(8'({mtv, i64, rcd}), 8'h1b);
    chk({cola, colb}, 8'h98);
    fb = 22'h080000;
    repeat (2) begin
      @(negedge clk);
      chk(8'({ra, rb}), 8'({1'b1, row_n}));
    end
    @(posedge clk) #1 fb = 22'h040000;
    repeat (2) begin
      @(negedge clk);
      chk(8'({ra, rb}), 8'({row_n, 1'b1}));
    end
    i_host.setup(2'h0, 1'b0, 1'b0);
    chk({cola, colb}, 8'h88);
    chk(8'(rcd), 8'h05);
    i_host.wr_reg(8'h43, 8'h10);
    repeat (2) begin
      @(negedge clk);
      chk(8'({ra, rb}), 8'({row_n, row_n}));
    end
    done("dram");
    for (int m = 0; m < 4; m++) begin
      i_host.wr_reg(8'h60, 8'(m));
      chk(8'(vmode), 8'(vm_t[m]));
    end
    i_host.wr_reg(8'h60, 8'h00);
    repeat (16) begin
      @(negedge clk);
      chk(8'(vclk), 8'(dot));
    end
    i_host.wr_reg(8'h60, 8'h40);
    n = 0;
    for (int i = 0; i < 64; i++) begin
      rv[0] = vclk;
      @(negedge clk);
      if (vclk && !rv[0]) n++;
    end
    chk(8'(n >= 3 && n <= 5), 8'h01);
    done("video");
    i_host.wr_reg(8'h62, 8'h04);
    i_host.wr_reg(8'h63, 8'h0a);
    gpi = 2'h0;
    repeat (3) @(posedge clk);
    i_host.rd_reg(8'h63, rv);
    chk(rv, 8'h02);
    chk(8'({gpoe, gpo, gpl}), 8'h1a);
    done("gpio");
    i_host.acc(16'h03d5, 1'b0, 1'b1, 8'h00);
    i_host.rel();
    chk(io_rdata, 8'h00);
    i_host.acc(16'h03d6, 1'b1, 1'b0, 8'h44);
    i_host.acc(16'h03d6, 1'b0, 1'b1, 8'h00);
    i_host.rel();
    chk(io_rdata, 8'h44);
    i_host.wr_reg(8'h50, 8'hff);
    i_host.rd_reg(8'h50, rv);
    chk(rv, 8'h00);
    done("decode");
    i_host.wr_reg(8'h42, 8'h04);
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    i_host.rd_reg(8'h42, rv);
    chk(rv, 8'h01);
    chk(8'(gpoe), 8'h00);
    done("rereset");
    conclude();
  end
endmodule : tb
bind dpc_top dpc_asserts u_chk (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .IO_ADDR(IO_ADDR),
  .IO_WR(IO_WR), .IO_RD(IO_RD), .IO_RDATA(IO_RDATA), .FB_ADDR(FB_ADDR), .MEM_TYPE(MEM_TYPE),
  .MEM_TYPE_VALID(MEM_TYPE_VALID), .COL_BITS_BANK_A(COL_BITS_BANK_A),
  .COL_BITS_BANK_B(COL_BITS_BANK_B), .RCD_HALF_CLKS(RCD_HALF_CLKS), .IFACE_IS_64(IFACE_IS_64),
  .ROW_STROBE_N(ROW_STROBE_N), .ROW_STROBE_BANK_A_N(ROW_STROBE_BANK_A_N),
  .ROW_STROBE_BANK_B_N(ROW_STROBE_BANK_B_N), .MEM_PINS_OE(MEM_PINS_OE),
  .VPORT_PINS_OE(VPORT_PINS_OE), .VPORT_MODE(VPORT_MODE), .LOW_POWER(LOW_POWER),
  .HSYNC_OE(HSYNC_OE), .VSYNC_OE(VSYNC_OE), .GENERAL_PIN_OE(GENERAL_PIN_OE), .IO_HIT(IO_HIT),
  .GENERAL_PIN_LOW_DATA(GENERAL_PIN_LOW_DATA));
`default_nettype wire
